// ---- core/co1_consts.svh ----
`ifndef CO1_CONSTS_SVH
`define CO1_CONSTS_SVH

`define CO1_ADDR_LOW        8'h30
`define CO1_ADDR_HIGH       8'h31

`define CO1_LOW_RESET       8'h00
`define CO1_HIGH_RESET      8'h3f

`define CO1_H_BATT_MON      7
`define CO1_H_LP_HOT        6
`define CO1_H_SYSTEM_POWER_MONITOR_HI       5
`define CO1_H_SYSTEM_POWER_MONITOR_LO       4
`define CO1_H_IN_SENSE      3
`define CO1_H_CHG_SENSE     2
`define CO1_H_SYSTEM_POWER_MONITOR_GAIN     1
`define CO1_H_FAST_LOOP     0

`define CO1_L_COMPARATOR_REFERENCE_SEL       7
`define CO1_L_COMPARATOR_POLARITY       6
`define CO1_L_DEG_HI        5
`define CO1_L_DEG_LO        4
`define CO1_L_LATCH_OFF     3
`define CO1_L_PASS_THRU     2

`define CO1_SYSTEM_POWER_MONITOR_BUS_BAT    2'h0
`define CO1_SYSTEM_POWER_MONITOR_BUS        2'h1
`define CO1_SYSTEM_POWER_MONITOR_RSVD       2'h2
`define CO1_SYSTEM_POWER_MONITOR_OFF        2'h3

`define CO1_CLK_NS          25
`define CO1_CYC_PER_US      (1000 / `CO1_CLK_NS)
`define CO1_DEG0_US         5
`define CO1_DEG1_US         2000
`define CO1_DEG2_US         20000
`define CO1_DEG3_US         5000000
`define CO1_DEG0_CYC        (`CO1_DEG0_US * `CO1_CYC_PER_US)

`define CO1_ILIM_FAST_MAX   8'h40
`define CO1_ILIM_FULL_MAX   8'h64
`define CO1_ILIM_RESET      8'h00

`endif

// ---- core/co1_pkg.sv ----
package co1_pkg;

	typedef enum logic [1:0]
	{
		CO1_CMP_RUN      = 2'b00,
		CO1_CMP_LATCHED  = 2'b01,
		CO1_CMP_RELEASED = 2'b10
	} co1_latch_t;

	typedef logic [27:0] co1_count_t;

endpackage

// ---- core/co1_top.sv ----
`timescale 1ns/100ps
`include "co1_consts.svh"

module co1_top #(
	parameter int DEG1_CYC = `CO1_DEG1_US * `CO1_CYC_PER_US,
	parameter int DEG2_CYC = `CO1_DEG2_US * `CO1_CYC_PER_US,
	parameter int DEG3_CYC = `CO1_DEG3_US * `CO1_CYC_PER_US
) (
	input  wire logic       mclk,
	input  wire logic       resetn,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       low_power_mode,
	input  wire logic       comparator_input_above,
	input  wire logic       charger_good_in,
	input  wire logic       pass_through_exit,
	input  wire logic       ilim_wr,
	input  wire logic [7:0] ilim_wdata,
	output logic [7:0]      reg_rdata_r,
	output logic            batt_current_monitor_buf_r,
	output logic            lowpower_hot_detect_r,
	output logic            sys_power_sense_r,
	output logic            sys_power_include_batt_r,
	output logic            input_sense_5mohm_r,
	output logic            charge_sense_5mohm_r,
	output logic            sys_power_gain_high_r,
	output logic            fast_loop_active_r,
	output logic [7:0]      host_input_current_limit_r,
	output logic            comparator_reference_low_r,
	output logic            comparator_output_r,
	output logic            converter_off_r,
	output logic            charger_good_indication_r,
	output logic            charge_current_zero_r,
	output logic            pass_through_active_r
);

	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] t);
		addr_hit = (a == t);
	endfunction

	function automatic co1_pkg::co1_count_t deg_limit(input logic [1:0] sel);
		unique case (sel)
			2'h0: deg_limit = co1_pkg::co1_count_t'(`CO1_DEG0_CYC);
			2'h1: deg_limit = co1_pkg::co1_count_t'(DEG1_CYC);
			2'h2: deg_limit = co1_pkg::co1_count_t'(DEG2_CYC);
			2'h3: deg_limit = co1_pkg::co1_count_t'(DEG3_CYC);
		endcase
	endfunction

	logic [7:0]             high_r;
	logic [7:0]             low_r;
	logic                   wr_low;
	logic                   wr_high;
	logic                   raw_low;
	logic                   fast_eff;
	logic [7:0]             ilim_max;
	co1_pkg::co1_count_t    deg_cnt_r;
	co1_pkg::co1_latch_t    latch_r;
	co1_pkg::co1_latch_t    latch_nxt;

	assign wr_low  = reg_wr && addr_hit(reg_addr, `CO1_ADDR_LOW);
	assign wr_high = reg_wr && addr_hit(reg_addr, `CO1_ADDR_HIGH);
	// Polarity 0 pulls the output low above threshold, 1 below.
	assign raw_low = low_r[`CO1_L_COMPARATOR_POLARITY] ? !comparator_input_above
		: comparator_input_above;
	assign fast_eff = high_r[`CO1_H_FAST_LOOP] && high_r[`CO1_H_IN_SENSE];
	assign ilim_max = fast_eff ? `CO1_ILIM_FAST_MAX : `CO1_ILIM_FULL_MAX;

	// High byte holds its last written value.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			high_r <= `CO1_HIGH_RESET;
		else if (wr_high)
			high_r <= reg_wdata;
	end

	// Low byte; the pass-through bit self-clears, a host write wins.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			low_r <= `CO1_LOW_RESET;
		else if (wr_low)
			low_r <= reg_wdata;
		else if (pass_through_exit)
			low_r[`CO1_L_PASS_THRU] <= 1'b0;
	end

	// Read data for the two offsets; any other address reads zero.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			reg_rdata_r <= 8'h00;
		else if (reg_rd)
		begin
			if (addr_hit(reg_addr, `CO1_ADDR_LOW))
				reg_rdata_r <= low_r;
			else if (addr_hit(reg_addr, `CO1_ADDR_HIGH))
				reg_rdata_r <= high_r;
			else
				reg_rdata_r <= 8'h00;
		end
	end

	// Monitor and sense selections.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			batt_current_monitor_buf_r <= 1'b0;
			lowpower_hot_detect_r      <= 1'b0;
			sys_power_sense_r          <= 1'b0;
			sys_power_include_batt_r   <= 1'b0;
			input_sense_5mohm_r        <= 1'b1;
			charge_sense_5mohm_r       <= 1'b1;
			sys_power_gain_high_r      <= 1'b1;
			fast_loop_active_r         <= 1'b1;
			comparator_reference_low_r <= 1'b0;
		end
		else
		begin
			batt_current_monitor_buf_r <= high_r[`CO1_H_BATT_MON]
				&& !low_power_mode;
			lowpower_hot_detect_r <= high_r[`CO1_H_LP_HOT]
				&& low_power_mode;
			sys_power_sense_r <= !low_power_mode
				&& (high_r[`CO1_H_SYSTEM_POWER_MONITOR_HI:`CO1_H_SYSTEM_POWER_MONITOR_LO] == `CO1_SYSTEM_POWER_MONITOR_BUS_BAT
				|| high_r[`CO1_H_SYSTEM_POWER_MONITOR_HI:`CO1_H_SYSTEM_POWER_MONITOR_LO] == `CO1_SYSTEM_POWER_MONITOR_BUS);
			sys_power_include_batt_r <= !low_power_mode
				&& high_r[`CO1_H_SYSTEM_POWER_MONITOR_HI:`CO1_H_SYSTEM_POWER_MONITOR_LO] == `CO1_SYSTEM_POWER_MONITOR_BUS_BAT;
			input_sense_5mohm_r   <= high_r[`CO1_H_IN_SENSE];
			charge_sense_5mohm_r  <= high_r[`CO1_H_CHG_SENSE];
			sys_power_gain_high_r <= high_r[`CO1_H_SYSTEM_POWER_MONITOR_GAIN];
			fast_loop_active_r    <= fast_eff;
			comparator_reference_low_r <= low_r[`CO1_L_COMPARATOR_REFERENCE_SEL];
		end
	end

	// Writes above the ceiling are ignored; a stored limit above the ceiling is clamped to it.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			host_input_current_limit_r <= `CO1_ILIM_RESET;
		else if (ilim_wr && ilim_wdata <= ilim_max)
			host_input_current_limit_r <= ilim_wdata;
		else if (host_input_current_limit_r > ilim_max)
			host_input_current_limit_r <= ilim_max;
	end

	// Rising edge passes at once; falling edge waits out the deglitch.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			deg_cnt_r           <= '0;
			comparator_output_r <= 1'b1;
		end
		else if (!raw_low)
		begin
			deg_cnt_r           <= '0;
			comparator_output_r <= 1'b1;
		end
		else if (comparator_output_r)
		begin
			if (deg_cnt_r >= deg_limit(low_r[`CO1_L_DEG_HI:`CO1_L_DEG_LO])
				- co1_pkg::co1_count_t'(1))
			begin
				comparator_output_r <= 1'b0;
				deg_cnt_r           <= '0;
			end
			else
				deg_cnt_r <= deg_cnt_r + co1_pkg::co1_count_t'(1);
		end
	end

	always_comb
	begin
		latch_nxt = latch_r;
		unique case (latch_r)
			co1_pkg::CO1_CMP_RUN:
				if (low_r[`CO1_L_LATCH_OFF] && !comparator_output_r)
					latch_nxt = co1_pkg::CO1_CMP_LATCHED;
			co1_pkg::CO1_CMP_LATCHED:
				if (comparator_output_r && low_r[`CO1_L_LATCH_OFF])
					latch_nxt = co1_pkg::CO1_CMP_RELEASED;
			co1_pkg::CO1_CMP_RELEASED:
				if (!comparator_output_r)
					latch_nxt = co1_pkg::CO1_CMP_LATCHED;
				else if (!low_r[`CO1_L_LATCH_OFF])
					latch_nxt = co1_pkg::CO1_CMP_RUN;
			default:
				latch_nxt = co1_pkg::CO1_CMP_RUN;
		endcase
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			latch_r <= co1_pkg::CO1_CMP_RUN;
		else
			latch_r <= latch_nxt;
	end

	// The stored limit register is never touched by the latch.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			converter_off_r           <= 1'b0;
			charger_good_indication_r <= 1'b0;
			charge_current_zero_r     <= 1'b0;
			pass_through_active_r     <= 1'b0;
		end
		else
		begin
			converter_off_r <= latch_nxt != co1_pkg::CO1_CMP_RUN;
			charger_good_indication_r <= charger_good_in
				&& latch_nxt == co1_pkg::CO1_CMP_RUN;
			charge_current_zero_r <= latch_nxt != co1_pkg::CO1_CMP_RUN;
			pass_through_active_r <= low_r[`CO1_L_PASS_THRU];
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	sequence s_latched;
		latch_r == co1_pkg::CO1_CMP_LATCHED;
	endsequence

	sequence s_cmp_back_high;
		comparator_output_r && low_r[`CO1_L_LATCH_OFF];
	endsequence

	sequence s_released;
		latch_r == co1_pkg::CO1_CMP_RELEASED;
	endsequence

	a_batt_buf_lp: assert property (
		low_power_mode ##1 1 |-> !batt_current_monitor_buf_r)
		else $error("battery buffer on in low power");
	a_batt_buf_on: assert property (
		high_r[`CO1_H_BATT_MON] && !low_power_mode |=> batt_current_monitor_buf_r)
		else $error("battery buffer not on");
	a_system_power_monitor_lp_off: assert property (
		low_power_mode |=> !sys_power_sense_r)
		else $error("system power sensing on in low power");
	a_fast_needs_sense: assert property (
		fast_loop_active_r |-> input_sense_5mohm_r)
		else $error("fast loop without 5 milliohm sense");
	a_ilim_ceiling: assert property (
		ilim_wr && ilim_wdata > ilim_max |=> $stable(host_input_current_limit_r)
		|| host_input_current_limit_r <= ilim_max)
		else $error("limit above ceiling accepted");
	a_fast_clamp: assert property (
		fast_eff ##1 fast_eff |-> host_input_current_limit_r <= `CO1_ILIM_FAST_MAX)
		else $error("limit above fast clamp");
	a_rise_fast: assert property (
		!raw_low |=> comparator_output_r)
		else $error("rising edge delayed");
	a_fall_deglitch: assert property (
		low_r[`CO1_L_DEG_HI:`CO1_L_DEG_LO] == 2'h0 && comparator_output_r
		&& raw_low && deg_cnt_r == '0 |-> comparator_output_r [*8])
		else $error("falling edge not deglitched");
	a_trip_latch: assert property (
		latch_r == co1_pkg::CO1_CMP_RUN && low_r[`CO1_L_LATCH_OFF]
		&& !comparator_output_r |=> converter_off_r && !charger_good_indication_r
		&& charge_current_zero_r)
		else $error("trip did not latch converter off");
	a_release_order: assert property (
		s_latched ##1 !comparator_output_r |-> converter_off_r)
		else $error("released while comparator low");
	a_release_arm: assert property (
		s_latched ##0 s_cmp_back_high |=> latch_r == co1_pkg::CO1_CMP_RELEASED)
		else $error("latch not armed for release");
	a_release_steps: assert property (
		s_released ##0 !low_r[`CO1_L_LATCH_OFF] && comparator_output_r
		|=> !converter_off_r)
		else $error("latch not released after both steps");
	a_lp_hot_gate: assert property (
		!low_power_mode |=> !lowpower_hot_detect_r)
		else $error("hot detection on outside low power");
	a_limit_kept: assert property (
		converter_off_r && !ilim_wr
		&& host_input_current_limit_r <= ilim_max
		|=> $stable(host_input_current_limit_r))
		else $error("limit changed while latched off");
	a_ptm_clear: assert property (
		pass_through_exit && !wr_low |=> !low_r[`CO1_L_PASS_THRU])
		else $error("pass-through bit not cleared");

endmodule

// ---- verification/co1_host_model.sv ----
`timescale 1ns/100ps
module co1_host_model (
	input  wire logic       mclk,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic [7:0]      reg_addr,
	output logic [7:0]      reg_wdata,
	input  wire logic [7:0] reg_rdata_r
);
	initial
	begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end

	// Writes one byte, then the data lines show the inverse.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
		reg_wdata = ~d;
		repeat (2) @(negedge mclk);
	endtask

	// Reads one byte once the registered answer has settled.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		@(negedge mclk);
		d = reg_rdata_r;
	endtask
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/100ps
`define CHK(g, e) \
	begin \
		total_checks++; \
		if ((g) !== (e)) \
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
		if ((g) !== (e)) \
			err_count++; \
	end
module tb_top;
	logic       mclk, resetn, low_power_mode, comparator_input_above;
	logic       charger_good_in, pass_through_exit, ilim_wr, reg_wr, reg_rd;
	logic [7:0] reg_addr, reg_wdata, reg_rdata_r, ilim_wdata, rd_d, h;
	logic       batt_current_monitor_buf_r, lowpower_hot_detect_r;
	logic       sys_power_sense_r, sys_power_include_batt_r;
	logic       input_sense_5mohm_r, charge_sense_5mohm_r;
	logic       sys_power_gain_high_r, fast_loop_active_r;
	logic [7:0] host_input_current_limit_r;
	logic       comparator_reference_low_r, comparator_output_r;
	logic       converter_off_r, charger_good_indication_r;
	logic       charge_current_zero_r, pass_through_active_r;
	logic [7:0] hv;
	int         err_count, total_checks, seed, dn[4];

	co1_top #(.DEG1_CYC(20), .DEG2_CYC(30), .DEG3_CYC(40)) u_dut (.*);
	co1_host_model u_host (.*);

	assign hv = {batt_current_monitor_buf_r, lowpower_hot_detect_r,
		sys_power_sense_r, sys_power_include_batt_r, input_sense_5mohm_r,
		charge_sense_5mohm_r, sys_power_gain_high_r, fast_loop_active_r};

	function automatic logic [7:0] exp_hi(logic [7:0] v, logic lp);
		exp_hi = {v[7] & ~lp, v[6] & lp, ~v[5] & ~lp, (v[5:4] == 2'h0) & ~lp,
			v[3], v[2], v[1], v[0] & v[3]};
	endfunction

	task automatic complete_run;
		$display("checks=%0d errors=%0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic lim(input logic [7:0] d, input logic [7:0] e);
		@(negedge mclk);
		ilim_wdata = d;
		ilim_wr = 1'b1;
		@(negedge mclk);
		ilim_wr = 1'b0;
		@(negedge mclk);
		`CHK(host_input_current_limit_r, e)
	endtask

	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	initial
	begin
		#(25 * 20000);
		err_count++;
		complete_run();
	end

	initial
	begin
		seed = 32'hcde5;
		dn = '{200, 20, 30, 40};
		resetn = 1'b0;
		low_power_mode = 1'b0;
		comparator_input_above = 1'b0;
		charger_good_in = 1'b1;
		pass_through_exit = 1'b0;
		ilim_wr = 1'b0;
		ilim_wdata = 8'h00;
		repeat (5) @(negedge mclk);
		resetn = 1'b1;
		u_host.rd(8'h30, rd_d);
		`CHK(rd_d, 8'h00);
		u_host.rd(8'h31, rd_d);
		`CHK(rd_d, 8'h3f);
		`CHK(hv, exp_hi(8'h3f, 1'b0));
		u_host.rd(8'h52, rd_d);
		`CHK(rd_d, 8'h00);
		repeat (16)
		begin
			h = 8'($random(seed));
			low_power_mode = 1'($random(seed));
			u_host.wr(8'h31, h);
			`CHK(hv, exp_hi(h, low_power_mode));
			u_host.rd(8'h31, rd_d);
			`CHK(rd_d, h);
		end
		low_power_mode = 1'b0;
		u_host.wr(8'h31, 8'h3f);
		lim(8'h41, 8'h00);
		lim(8'h40, 8'h40);
		lim(8'h64, 8'h40);
		u_host.wr(8'h31, 8'h3e);
		lim(8'h65, 8'h40);
		lim(8'h64, 8'h64);
		u_host.wr(8'h31, 8'h3f);
		`CHK(host_input_current_limit_r, 8'h40);
		u_host.wr(8'h30, 8'h80);
		`CHK(comparator_reference_low_r, 1'b1);
		u_host.wr(8'h30, 8'h40);
		repeat (210) @(negedge mclk);
		`CHK(comparator_output_r, 1'b0);
		comparator_input_above = 1'b1;
		repeat (2) @(negedge mclk);
		`CHK(comparator_output_r, 1'b1);
		for (int k = 0; k < 4; k++)
		begin
			comparator_input_above = 1'b0;
			u_host.wr(8'h30, {2'b00, 2'(k), 4'h0});
			comparator_input_above = 1'b1;
			repeat (dn[k] - 5) @(negedge mclk);
			`CHK(comparator_output_r, 1'b1);
			repeat (10) @(negedge mclk);
			`CHK(comparator_output_r, 1'b0);
		end
		comparator_input_above = 1'b0;
		u_host.wr(8'h30, 8'h08);
		comparator_input_above = 1'b1;
		repeat (210) @(negedge mclk);
		`CHK({converter_off_r, charger_good_indication_r}, 2'b10);
		`CHK(charge_current_zero_r, 1'b1);
		`CHK(host_input_current_limit_r, 8'h40);
		u_host.wr(8'h30, 8'h00);
		comparator_input_above = 1'b0;
		repeat (3) @(negedge mclk);
		`CHK(converter_off_r, 1'b1);
		u_host.wr(8'h30, 8'h08);
		`CHK(converter_off_r, 1'b1);
		u_host.wr(8'h30, 8'h00);
		`CHK({converter_off_r, charger_good_indication_r}, 2'b01);
		charger_good_in = 1'b0;
		repeat (2) @(negedge mclk);
		`CHK(charger_good_indication_r, 1'b0);
		charger_good_in = 1'b1;
		repeat (2) @(negedge mclk);
		`CHK(charger_good_indication_r, 1'b1);
		u_host.wr(8'h30, 8'h04);
		`CHK(pass_through_active_r, 1'b1);
		pass_through_exit = 1'b1;
		@(negedge mclk);
		pass_through_exit = 1'b0;
		repeat (2) @(negedge mclk);
		`CHK(pass_through_active_r, 1'b0);
		u_host.rd(8'h30, rd_d);
		`CHK(rd_d, 8'h00);
		complete_run();
	end
endmodule
